// [rrx_exec.sv]
`timescale 1ns/1ps
// Functional notes
// - or accumulator into memory, update zero
// - return: pc from stack, flags kept
// - return with literal: also load accumulator
// - interrupt return: pc from stack, enable set
// - pending interrupt served before resuming there
// - rotate memory left, bit7 to bit0
// - rotate left into accumulator, memory kept
// - nine-bit rotate through carry into memory
// - nine-bit rotate through carry into accumulator
module rrx_exec (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    input  wire logic                i_valid,
    input  wire logic [3:0]          i_op,
    input  wire logic [7:0]          i_mem_rdata,
    input  wire logic [7:0]          i_literal,
    input  wire logic [12:0]         i_stack_top,
    input  wire logic                i_irq_pending,
    output logic      [7:0]          o_acc,
    output logic                     o_carry,
    output logic                     o_zero,
    output logic                     o_global_interrupt_enable,
    output logic      [12:0]         o_pc,
    output logic                     o_pc_load,
    output logic                     o_stack_pop,
    output logic                     o_irq_take,
    output logic                     o_mem_we,
    output logic      [7:0]          o_mem_wdata
);

    // ------------------------------------------------------------
    // rotation datapath
    // ------------------------------------------------------------
    rrx_pkg::rrx_op_t op;
    logic [7:0]       rot_byte;
    logic             rot_carry;
    logic             thru_carry;

    assign op         = rrx_pkg::rrx_op_t'(i_op);
    assign thru_carry = (op == rrx_pkg::RRX_OP_ROTATE_LEFT_THROUGH_CARRY) ||
                        (op == rrx_pkg::RRX_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR);

    rrx_rotl #(
        .W (rrx_pkg::RRX_DATA_W)
    ) u_rotl (
        .i_byte       (i_mem_rdata),
        .i_carry      (o_carry),
        .i_thru_carry (thru_carry),
        .o_byte       (rot_byte),
        .o_carry      (rot_carry)
    );

    // ------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------
    logic [7:0]  acc_q, acc_d;
    logic        carry_q, carry_d;
    logic        zero_q, zero_d;
    logic        gie_q, gie_d;
    logic [12:0] pc_q, pc_d;
    logic        pc_load_q, pc_load_d;
    logic        pop_q, pop_d;
    logic        irq_take_q, irq_take_d;
    logic        mem_we_q, mem_we_d;
    logic [7:0]  mem_wdata_q, mem_wdata_d;
    logic [7:0]  or_res;

    assign or_res = i_mem_rdata | acc_q;

    // next-state decode for one executed instruction
    always_comb
    begin
        acc_d       = acc_q;
        carry_d     = carry_q;
        zero_d      = zero_q;
        gie_d       = gie_q;
        pc_d        = pc_q;
        pc_load_d   = 1'b0;
        pop_d       = 1'b0;
        irq_take_d  = 1'b0;
        mem_we_d    = 1'b0;
        mem_wdata_d = mem_wdata_q;
        if (i_valid)
        begin
            unique case (op)
                rrx_pkg::RRX_OP_OR_INTO_MEMORY:
                begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = or_res;
                    zero_d      = (or_res == 8'h00);
                end
                rrx_pkg::RRX_OP_SUBROUTINE_EXIT:
                begin
                    pc_d      = i_stack_top;
                    pc_load_d = 1'b1;
                    pop_d     = 1'b1;
                end
                rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL:
                begin
                    pc_d      = i_stack_top;
                    pc_load_d = 1'b1;
                    pop_d     = 1'b1;
                    acc_d     = i_literal;
                end
                rrx_pkg::RRX_OP_INTERRUPT_EXIT:
                begin
                    pc_d       = i_stack_top;
                    pc_load_d  = 1'b1;
                    pop_d      = 1'b1;
                    gie_d      = 1'b1;
                    irq_take_d = i_irq_pending;
                end
                rrx_pkg::RRX_OP_ROTATE_LEFT_PLAIN:
                begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = rot_byte;
                end
                rrx_pkg::RRX_OP_ROTATE_LEFT_TO_ACCUMULATOR:
                begin
                    acc_d = rot_byte;
                end
                rrx_pkg::RRX_OP_ROTATE_LEFT_THROUGH_CARRY:
                begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = rot_byte;
                    carry_d     = rot_carry;
                end
                rrx_pkg::RRX_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR:
                begin
                    acc_d   = rot_byte;
                    carry_d = rot_carry;
                end
                default:
                begin
                    acc_d = acc_q; // other codes execute nothing here
                end
            endcase
        end
    end

    // register all state
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_q       <= rrx_pkg::RRX_BYTE_RST;
            carry_q     <= 1'b0;
            zero_q      <= 1'b0;
            gie_q       <= 1'b0;
            pc_q        <= rrx_pkg::RRX_PC_RST;
            pc_load_q   <= 1'b0;
            pop_q       <= 1'b0;
            irq_take_q  <= 1'b0;
            mem_we_q    <= 1'b0;
            mem_wdata_q <= rrx_pkg::RRX_BYTE_RST;
        end
        else
        begin
            acc_q       <= acc_d;
            carry_q     <= carry_d;
            zero_q      <= zero_d;
            gie_q       <= gie_d;
            pc_q        <= pc_d;
            pc_load_q   <= pc_load_d;
            pop_q       <= pop_d;
            irq_take_q  <= irq_take_d;
            mem_we_q    <= mem_we_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // outputs straight from flops
    assign o_acc                     = acc_q;
    assign o_carry                   = carry_q;
    assign o_zero                    = zero_q;
    assign o_global_interrupt_enable = gie_q;
    assign o_pc                      = pc_q;
    assign o_pc_load                 = pc_load_q;
    assign o_stack_pop               = pop_q;
    assign o_irq_take                = irq_take_q;
    assign o_mem_we                  = mem_we_q;
    assign o_mem_wdata               = mem_wdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ret_issue;
        i_valid && (op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT ||
                    op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL ||
                    op == rrx_pkg::RRX_OP_INTERRUPT_EXIT);
    endsequence

    sequence s_one_pop;
        o_stack_pop ##1 !o_stack_pop;
    endsequence

    or_memory_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_OR_INTO_MEMORY |=> o_mem_we &&
        o_mem_wdata == ($past(i_mem_rdata) | $past(acc_q)) && o_zero == (o_mem_wdata == 8'h00))
        else $error("or into memory wrong");

    ret_pc_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_ret_issue |=> o_pc_load && o_pc == $past(i_stack_top) && $stable(o_zero) && $stable(o_carry))
        else $error("return did not restore pc");

    ret_literal_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL |=> o_acc == $past(i_literal))
        else $error("literal not loaded");

    interrupt_exit_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_INTERRUPT_EXIT |=> o_global_interrupt_enable)
        else $error("interrupt enable not set");

    interrupt_exit_pending_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_INTERRUPT_EXIT && i_irq_pending |=> o_irq_take && o_pc_load)
        else $error("pending interrupt not taken");

    rotl_plain_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_ROTATE_LEFT_PLAIN |=> o_mem_we &&
        o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} && $stable(o_carry))
        else $error("plain rotate wrong");

    rotl_acc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_ROTATE_LEFT_TO_ACCUMULATOR |=> !o_mem_we &&
        o_acc == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])})
        else $error("rotate to accumulator wrong");

    rotl_carry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_ROTATE_LEFT_THROUGH_CARRY |=> o_mem_we &&
        o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(carry_q)} && o_carry == $past(i_mem_rdata[7]))
        else $error("rotate through carry wrong");

    rotl_carry_acc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid && op == rrx_pkg::RRX_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR |=> !o_mem_we &&
        o_acc == {$past(i_mem_rdata[6:0]), $past(carry_q)} && o_carry == $past(i_mem_rdata[7]))
        else $error("rotate carry to accumulator wrong");

    ret_one_pop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_ret_issue ##1 !i_valid |-> s_one_pop)
        else $error("return popped wrong count");

endmodule : rrx_exec

// [rrx_pkg.sv]
package rrx_pkg;

    // ------------------------------------------------------------
    // operation select codes
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        RRX_OP_NONE                             = 4'h0,
        RRX_OP_OR_INTO_MEMORY                   = 4'h1,
        RRX_OP_SUBROUTINE_EXIT                  = 4'h2,
        RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL     = 4'h3,
        RRX_OP_INTERRUPT_EXIT                   = 4'h4,
        RRX_OP_ROTATE_LEFT_PLAIN                = 4'h5,
        RRX_OP_ROTATE_LEFT_TO_ACCUMULATOR       = 4'h6,
        RRX_OP_ROTATE_LEFT_THROUGH_CARRY        = 4'h7,
        RRX_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR = 4'h8
    } rrx_op_t;

    // ------------------------------------------------------------
    // widths, bit positions and reset values
    // ------------------------------------------------------------
    localparam int          RRX_DATA_W   = 8;
    localparam int          RRX_PC_W     = 13;
    localparam int          RRX_MSB_POS  = 7;
    localparam int          RRX_LSB_POS  = 0;
    localparam logic [7:0]  RRX_BYTE_RST = 8'h00;
    localparam logic [12:0] RRX_PC_RST   = 13'h0000;

endpackage : rrx_pkg

// [rrx_rotl.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// one-bit left rotation, circular or through a carry bit
// ------------------------------------------------------------
module rrx_rotl #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_byte,
    input  wire logic         i_carry,
    input  wire logic         i_thru_carry,
    output logic      [W-1:0] o_byte,
    output logic              o_carry
);

    // bit 0 takes old msb, or old carry when rotating through carry
    always_comb
    begin
        o_byte  = {i_byte[W-2:0], (i_thru_carry ? i_carry : i_byte[W-1])};
        o_carry = i_byte[W-1];
    end

endmodule : rrx_rotl

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic        i_clk_sys     = 1'b0;
    logic        i_rst_n       = 1'b0;
    logic        i_valid       = 1'b0;
    logic [3:0]  i_op          = 4'h0;
    logic [7:0]  i_mem_rdata   = 8'h00;
    logic [7:0]  i_literal     = 8'h00;
    logic [12:0] i_stack_top   = 13'h0000;
    logic        i_irq_pending = 1'b0;
    logic [7:0]  o_acc;
    logic        o_carry;
    logic        o_zero;
    logic        o_gie;
    logic [12:0] o_pc;
    logic        o_pc_load;
    logic        o_stack_pop;
    logic        o_irq_take;
    logic        o_mem_we;
    logic [7:0]  o_mem_wdata;
    int          num_errors    = 0;
    int          n_tests       = 0;

    // ------------------------------------------------------------
    // clock, design
    // ------------------------------------------------------------
    // 100 MHz system clock
    always #5 i_clk_sys = ~i_clk_sys;

    rrx_exec i_rrx_exec (
        .i_clk_sys                 (i_clk_sys),
        .i_rst_n                   (i_rst_n),
        .i_valid                   (i_valid),
        .i_op                      (i_op),
        .i_mem_rdata               (i_mem_rdata),
        .i_literal                 (i_literal),
        .i_stack_top               (i_stack_top),
        .i_irq_pending             (i_irq_pending),
        .o_acc                     (o_acc),
        .o_carry                   (o_carry),
        .o_zero                    (o_zero),
        .o_global_interrupt_enable (o_gie),
        .o_pc                      (o_pc),
        .o_pc_load                 (o_pc_load),
        .o_stack_pop               (o_stack_pop),
        .o_irq_take                (o_irq_take),
        .o_mem_we                  (o_mem_we),
        .o_mem_wdata               (o_mem_wdata)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one instruction, returns with its results settled on the outputs
    task automatic ex(input logic [3:0] op, input logic [7:0] m, input logic [7:0] l,
                      input logic [12:0] s, input logic q);
        @(posedge i_clk_sys);
        i_valid       <= 1'b1;
        i_op          <= op;
        i_mem_rdata   <= m;
        i_literal     <= l;
        i_stack_top   <= s;
        i_irq_pending <= q;
        @(posedge i_clk_sys);
        i_valid       <= 1'b0;
        i_mem_rdata   <= ~m;
        #1;
    endtask : ex

    // pulses as {pc_load, stack_pop, irq_take, mem_we}
    task automatic pulses(input logic [3:0] e);
        chk("pulses", {9'h000, e}, {9'h000, o_pc_load, o_stack_pop, o_irq_take, o_mem_we});
    endtask : pulses

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // returns restore pc, pop once; plain return keeps acc and gie; pulses last one cycle
    task automatic t_returns();
        ex(rrx_pkg::RRX_OP_SUBROUTINE_EXIT, 8'h00, 8'h5a, 13'h1abc, 1'b1);
        chk("pc", 13'h1abc, o_pc);
        pulses(4'hc);
        chk("acc", 13'h000f, {5'h00, o_acc});
        chk("gie", 13'h0000, {12'h000, o_gie});
        @(posedge i_clk_sys);
        #1;
        pulses(4'h0);
        ex(rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL, 8'h00, 8'ha5, 13'h0123, 1'b0);
        chk("pc", 13'h0123, o_pc);
        chk("acc", 13'h00a5, {5'h00, o_acc});
        pulses(4'hc);
        ex(rrx_pkg::RRX_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h0f0f, 1'b0);
        chk("gie", 13'h0001, {12'h000, o_gie});
        chk("pc", 13'h0f0f, o_pc);
        pulses(4'hc);
        ex(rrx_pkg::RRX_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h1001, 1'b1);
        pulses(4'he);
        chk("pc", 13'h1001, o_pc);
    endtask : t_returns

    // the four left rotations, carry chained between them
    task automatic t_rotates();
        ex(rrx_pkg::RRX_OP_ROTATE_LEFT_THROUGH_CARRY, 8'h81, 8'h00, 13'h0000, 1'b0);
        chk("wdata", 13'h0002, {5'h00, o_mem_wdata});
        chk("carry", 13'h0001, {12'h000, o_carry});
        pulses(4'h1);
        ex(rrx_pkg::RRX_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR, 8'h40, 8'h00, 13'h0000, 1'b0);
        chk("acc", 13'h0081, {5'h00, o_acc});
        chk("carry", 13'h0000, {12'h000, o_carry});
        pulses(4'h0);
        ex(rrx_pkg::RRX_OP_ROTATE_LEFT_PLAIN, 8'h81, 8'h00, 13'h0000, 1'b0);
        chk("wdata", 13'h0003, {5'h00, o_mem_wdata});
        chk("carry", 13'h0000, {12'h000, o_carry});
        pulses(4'h1);
        ex(rrx_pkg::RRX_OP_ROTATE_LEFT_TO_ACCUMULATOR, 8'h87, 8'h00, 13'h0000, 1'b0);
        chk("acc", 13'h000f, {5'h00, o_acc});
        chk("carry", 13'h0000, {12'h000, o_carry});
        pulses(4'h0);
    endtask : t_rotates

    // or into memory sets and clears zero; unknown op changes nothing
    task automatic t_or_refuse();
        ex(rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL, 8'h00, 8'h0f, 13'h0000, 1'b0);
        ex(rrx_pkg::RRX_OP_OR_INTO_MEMORY, 8'hf0, 8'h00, 13'h0000, 1'b0);
        chk("wdata", 13'h00ff, {5'h00, o_mem_wdata});
        chk("zero", 13'h0000, {12'h000, o_zero});
        pulses(4'h1);
        ex(rrx_pkg::RRX_OP_SUBROUTINE_EXIT_WITH_LITERAL, 8'h00, 8'h00, 13'h0000, 1'b0);
        ex(rrx_pkg::RRX_OP_OR_INTO_MEMORY, 8'h00, 8'h00, 13'h0000, 1'b0);
        chk("wdata", 13'h0000, {5'h00, o_mem_wdata});
        chk("zero", 13'h0001, {12'h000, o_zero});
        ex(4'h9, 8'hff, 8'h77, 13'h1fff, 1'b1);
        pulses(4'h0);
        chk("acc", 13'h0000, {5'h00, o_acc});
        chk("zero", 13'h0001, {12'h000, o_zero});
        chk("pc", 13'h0000, o_pc);
    endtask : t_or_refuse

    // ------------------------------------------------------------
    // verdict, watchdog, main sequence
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // the tests need under 100 cycles; allow 2000
    initial
    begin
        #20000;
        num_errors++;
        give_verdict();
    end

    // reset for 8 cycles, then the scenarios
    initial
    begin
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        #1;
        pulses(4'h0);
        chk("acc", 13'h0000, {5'h00, o_acc});
        t_rotates();
        t_returns();
        t_or_refuse();
        give_verdict();
    end
endmodule : testbench
